// >>> rtl/bdm_pkg.sv
// Shared constants for the banked data memory with indirect access ports.
// Assumes an 8-bit core on one clock that issues one access per cycle.
package bdm_pkg;

  localparam int unsigned DATA_W       = 8;
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned GP_DEPTH     = 128;
  localparam int unsigned GP_ADDR_W    = 7;

  // Addresses of the special-function locations held in this block.
  localparam logic [7:0] ADDR_IND_A    = 8'h00;
  localparam logic [7:0] ADDR_PTR_A    = 8'h01;
  localparam logic [7:0] ADDR_IND_B    = 8'h02;
  localparam logic [7:0] ADDR_PTR_B    = 8'h03;
  localparam logic [7:0] ADDR_BANK     = 8'h04;
  localparam logic [7:0] ADDR_BANK1_ONLY = 8'h40;
  localparam logic [7:0] ADDR_LOWEST   = 8'h00;
  localparam logic [7:0] GP_BASE       = 8'h80;

  // Values after reset.
  localparam logic       RST_BANK      = 1'b0;
  localparam logic [7:0] RST_PTR       = 8'h00;
  localparam logic [7:0] RST_RDATA     = 8'h00;
  localparam logic [7:0] NULL_DATA     = 8'h00;
  localparam int unsigned BANK_BIT_POS = 0;

  // Where an access lands once the address has been resolved.
  typedef enum logic [2:0] {
    BDM_TGT_NONE  = 3'b000,
    BDM_TGT_RAM   = 3'b001,
    BDM_TGT_PTR_A = 3'b010,
    BDM_TGT_PTR_B = 3'b011,
    BDM_TGT_BANK  = 3'b100,
    BDM_TGT_SFR   = 3'b101
  } bdm_target_t;

endpackage

// >>> rtl/bdm_gp_ram.sv
// General-purpose data array with one write port and an asynchronous read.
// Assumes the caller registers the read data and resolves all banking.
`timescale 1ns/1ns
module bdm_gp_ram #(
  parameter int unsigned DEPTH  = bdm_pkg::GP_DEPTH,
  parameter int unsigned AW     = bdm_pkg::GP_ADDR_W,
  parameter int unsigned DW     = bdm_pkg::DATA_W
) (
  // Clock
  input  wire logic          clk_in,
  // Write port
  input  wire logic          we_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [DW-1:0] wdata_in,
  // Read port
  input  wire logic [AW-1:0] raddr_in,
  output logic      [DW-1:0] rdata_out
);

  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk_in)
  begin
    if (we_in)
    begin
      mem[waddr_in] <= wdata_in;
    end
  end

  assign rdata_out = mem[raddr_in];

endmodule

// >>> rtl/bdm_data_memory.sv
// Data memory addressing: banking, two indirect ports, pointers, bank select.
// Assumes the core drives one access per cycle on clk_in and that other
// special-function registers live outside and answer in the same cycle.
//
// Function
// - Provide 128 volatile data memory locations, 8 bits each.
// - General-purpose locations are freely readable and writable.
// - Two banks; special registers reachable in any bank, 40H only in bank 1.
// - Data memory addressing starts at address 00H.
// - Accesses to indirect ports go to the location their pointer holds.
// - Port a reaches bank 0 only; port b reaches the selected bank.
// - Indirect access to an indirect port reads 00H, writes do nothing.
// - Both pointers are real, readable and writable memory locations.
// - Direct accesses always reach bank 0; bank 1 only through port b.
// - Bank choice comes from bit 0 of the bank select register.
// - Resets clear the bank, except a watchdog reset during power-down.
// - Bank select implements bit 0 only; upper bits read zero; clears at power-on.
`timescale 1ns/1ns
module bdm_data_memory (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  // Reset events from the system controller, one-cycle pulses
  input  wire logic       sys_reset_in,
  input  wire logic       wdt_pd_reset_in,
  // Core access port
  input  wire logic       acc_valid_in,
  input  wire logic       acc_write_in,
  input  wire logic [7:0] acc_addr_in,
  input  wire logic [7:0] acc_wdata_in,
  // Core read answer
  output logic            rd_valid_out,
  output logic      [7:0] rd_data_out,
  // External special-function register port
  output logic            sfr_valid_out,
  output logic            sfr_write_out,
  output logic            sfr_bank_out,
  output logic      [7:0] sfr_addr_out,
  output logic      [7:0] sfr_wdata_out,
  input  wire logic [7:0] sfr_rdata_in,
  // Visible state
  output logic            bank_sel_out,
  output logic      [7:0] pointer_a_out,
  output logic      [7:0] pointer_b_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Address resolution

  logic              via_ind;
  logic              eff_bank;
  logic [7:0]        eff_addr;
  bdm_pkg::bdm_target_t tgt;
  logic [7:0]        ram_rdata;
  logic              bank_select_bit;
  logic [7:0]        pointer_a;
  logic [7:0]        pointer_b;

  always_comb
  begin
    via_ind  = 1'b0;
    eff_bank = 1'b0;
    eff_addr = acc_addr_in;
    if (acc_addr_in == bdm_pkg::ADDR_IND_A)
    begin
      via_ind  = 1'b1;
      eff_bank = 1'b0;
      eff_addr = pointer_a;
    end
    else if (acc_addr_in == bdm_pkg::ADDR_IND_B)
    begin
      via_ind  = 1'b1;
      eff_bank = bank_select_bit;
      eff_addr = pointer_b;
    end
    // direct accesses stay in bank 0
    tgt = bdm_pkg::BDM_TGT_NONE;
    if (!acc_valid_in)
    begin
      tgt = bdm_pkg::BDM_TGT_NONE;
    end
    // indirect port seen indirectly is null
    else if (via_ind && (eff_addr == bdm_pkg::ADDR_IND_A ||
                         eff_addr == bdm_pkg::ADDR_IND_B))
    begin
      tgt = bdm_pkg::BDM_TGT_NONE;
    end
    else if (eff_addr >= bdm_pkg::GP_BASE)
    begin
      // Bank 1 holds no general-purpose bytes, so it reads as zero there.
      tgt = eff_bank ? bdm_pkg::BDM_TGT_NONE : bdm_pkg::BDM_TGT_RAM;
    end
    else if (eff_addr == bdm_pkg::ADDR_PTR_A)
    begin
      tgt = bdm_pkg::BDM_TGT_PTR_A;
    end
    else if (eff_addr == bdm_pkg::ADDR_PTR_B)
    begin
      tgt = bdm_pkg::BDM_TGT_PTR_B;
    end
    else if (eff_addr == bdm_pkg::ADDR_BANK)
    begin
      tgt = bdm_pkg::BDM_TGT_BANK;
    end
    else if (eff_addr == bdm_pkg::ADDR_BANK1_ONLY)
    begin
      tgt = eff_bank ? bdm_pkg::BDM_TGT_SFR : bdm_pkg::BDM_TGT_NONE;
    end
    else
    begin
      tgt = bdm_pkg::BDM_TGT_SFR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  logic ram_we;

  assign ram_we = (tgt == bdm_pkg::BDM_TGT_RAM) && acc_write_in;

  bdm_gp_ram #(
    .DEPTH (bdm_pkg::GP_DEPTH),
    .AW    (bdm_pkg::GP_ADDR_W),
    .DW    (bdm_pkg::DATA_W)
  ) u_ram (
    .clk_in    (clk_in),
    .we_in     (ram_we),
    .waddr_in  (eff_addr[6:0]),
    .wdata_in  (acc_wdata_in),
    .raddr_in  (eff_addr[6:0]),
    .rdata_out (ram_rdata)
  );

  // The outer register port is a same-cycle strobe; reads must answer at once.
  assign sfr_valid_out = (tgt == bdm_pkg::BDM_TGT_SFR);
  assign sfr_write_out = sfr_valid_out && acc_write_in;
  assign sfr_bank_out  = eff_bank;
  assign sfr_addr_out  = eff_addr;
  assign sfr_wdata_out = acc_wdata_in;

  ////////////////////////////////////////////////////////////////////////////
  // Pointers, bank select and read answer

  logic       next_bank_select_bit;
  logic [7:0] next_pointer_a;
  logic [7:0] next_pointer_b;
  logic       next_rd_valid;
  logic [7:0] next_rd_data;
  logic       wr;

  always_comb
  begin
    wr                   = acc_write_in;
    next_pointer_a       = pointer_a;
    next_pointer_b       = pointer_b;
    next_bank_select_bit = bank_select_bit;
    next_rd_valid        = acc_valid_in && !acc_write_in;
    next_rd_data         = bdm_pkg::NULL_DATA;
    unique case (tgt)
      bdm_pkg::BDM_TGT_NONE:
      begin
        next_rd_data = bdm_pkg::NULL_DATA;
      end
      bdm_pkg::BDM_TGT_RAM:
      begin
        next_rd_data = ram_rdata;
      end
      bdm_pkg::BDM_TGT_PTR_A:
      begin
        next_rd_data = pointer_a;
        if (wr)
        begin
          next_pointer_a = acc_wdata_in;
        end
      end
      bdm_pkg::BDM_TGT_PTR_B:
      begin
        next_rd_data = pointer_b;
        if (wr)
        begin
          next_pointer_b = acc_wdata_in;
        end
      end
      bdm_pkg::BDM_TGT_BANK:
      begin
        next_rd_data = {7'h00, bank_select_bit};
        if (wr)
        begin
          next_bank_select_bit = acc_wdata_in[bdm_pkg::BANK_BIT_POS];
        end
      end
      bdm_pkg::BDM_TGT_SFR:
      begin
        next_rd_data = sfr_rdata_in;
      end
      default:
      begin
        next_rd_data = bdm_pkg::NULL_DATA;
      end
    endcase
    // reset events on the bank
    // A watchdog reset in power-down is deliberately ignored here.
    if (sys_reset_in)
    begin
      next_bank_select_bit = bdm_pkg::RST_BANK;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      bank_select_bit <= bdm_pkg::RST_BANK;
      pointer_a       <= bdm_pkg::RST_PTR;
      pointer_b       <= bdm_pkg::RST_PTR;
      rd_valid_out    <= 1'b0;
      rd_data_out     <= bdm_pkg::RST_RDATA;
    end
    else
    begin
      bank_select_bit <= next_bank_select_bit;
      pointer_a       <= next_pointer_a;
      pointer_b       <= next_pointer_b;
      rd_valid_out    <= next_rd_valid;
      rd_data_out     <= next_rd_data;
    end
  end

  assign bank_sel_out  = bank_select_bit;
  assign pointer_a_out = pointer_a;
  assign pointer_b_out = pointer_b;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  chk_ind_null_read: assert property (
    (acc_valid_in && !acc_write_in && acc_addr_in == bdm_pkg::ADDR_IND_A &&
     pointer_a == bdm_pkg::ADDR_IND_B) |=> (rd_valid_out && rd_data_out == 8'h00))
    else $error("indirect port read indirectly did not return zero");
  chk_bank_upper_zero: assert property (
    (acc_valid_in && !acc_write_in && acc_addr_in == bdm_pkg::ADDR_BANK)
    |=> (rd_data_out[7:1] == 7'h00 && rd_data_out[0] == $past(bank_select_bit)))
    else $error("bank select read value wrong");
  chk_bank_write: assert property (
    (acc_valid_in && acc_write_in && acc_addr_in == bdm_pkg::ADDR_BANK &&
     !sys_reset_in) |=> (bank_select_bit == $past(acc_wdata_in[0])))
    else $error("bank select bit not taken from data bit 0");
  chk_sys_reset_bank: assert property (
    sys_reset_in |=> !bank_select_bit)
    else $error("system reset did not return to bank 0");
  chk_wdt_pd_keep: assert property (
    (wdt_pd_reset_in && !sys_reset_in && !acc_valid_in) |=> $stable(bank_select_bit))
    else $error("watchdog power-down reset changed the bank");
  chk_port_a_bank0: assert property (
    (acc_valid_in && acc_addr_in == bdm_pkg::ADDR_IND_A)
    |-> (!eff_bank && (!pointer_a[7] || tgt == bdm_pkg::BDM_TGT_RAM)))
    else $error("port a reached bank 1");
  chk_direct_bank0: assert property (
    (acc_valid_in && acc_addr_in != bdm_pkg::ADDR_IND_B)
    |-> (!eff_bank && (!acc_addr_in[7] || tgt == bdm_pkg::BDM_TGT_RAM)))
    else $error("direct or port a access left bank 0");
  chk_ptr_b_addr: assert property (
    (acc_valid_in && acc_addr_in == bdm_pkg::ADDR_IND_B)
    |-> (eff_addr == pointer_b && eff_bank == bank_select_bit))
    else $error("port b effective address wrong");
  chk_reg40_bank1: assert property (
    (acc_valid_in && eff_addr == bdm_pkg::ADDR_BANK1_ONLY) |-> (sfr_valid_out == eff_bank))
    else $error("location 40H reachable outside bank 1");
  chk_ram_roundtrip: assert property (
    (acc_valid_in && acc_write_in && acc_addr_in == bdm_pkg::GP_BASE) ##1
    (acc_valid_in && !acc_write_in && acc_addr_in == bdm_pkg::GP_BASE)
    |=> (rd_data_out == $past(acc_wdata_in, 2)))
    else $error("general-purpose byte did not read back");
  chk_ptr_a_write: assert property (
    (acc_valid_in && acc_write_in && acc_addr_in == bdm_pkg::ADDR_PTR_A)
    |=> (pointer_a == $past(acc_wdata_in)))
    else $error("pointer a write lost");
  cov_ind_b_bank1: cover property (
    acc_valid_in && acc_addr_in == bdm_pkg::ADDR_IND_B && bank_select_bit);
  cov_ind_a_ram: cover property (
    acc_valid_in && acc_addr_in == bdm_pkg::ADDR_IND_A && tgt == bdm_pkg::BDM_TGT_RAM);
  cov_reg40: cover property (sfr_valid_out && sfr_addr_out == bdm_pkg::ADDR_BANK1_ONLY);
  cov_wdt_keep: cover property (bank_select_bit && wdt_pd_reset_in);

endmodule

// >>> testbench/bdm_sfr_model.sv
// External special-function registers behind the block's register port.
// Assumes one register per address, shared by both banks.
`timescale 1ns/1ns
module bdm_sfr_model (
  // Clock
  input  wire logic       clk_in,
  // Access from the block
  input  wire logic       valid_in,
  input  wire logic       write_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  // Answer
  output logic      [7:0] rdata_out
);
  logic [7:0] mem [256];
  logic [7:0] last;
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5a;
    last = 8'h00;
  end
  always @(posedge clk_in)
    if (valid_in && write_in)
      mem[addr_in] <= wdata_in;
  // An idle port shows the inverse of the last answer, so stale data never matches.
  always @(posedge clk_in)
    if (valid_in)
      last <= mem[addr_in];
  assign rdata_out = valid_in ? mem[addr_in] : ~last;
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for the banked data memory with indirect ports.
// Assumes bdm_sfr_model answers the external register port.
`timescale 1ns/1ns
module tb_top;
  logic       clk, rstn, sr, wr, v, w, rv, sv, sw, sb, bo;
  logic [7:0] a, d, srd, rd, sa, sd, pao, pbo, pa, pb;
  logic       bk;
  logic [7:0] ram [128];
  logic [7:0] sfr [256];
  int         n_mismatch;
  int         cmp_count;

  bdm_data_memory dut (
    .clk_in(clk), .rstn_in(rstn), .sys_reset_in(sr), .wdt_pd_reset_in(wr),
    .acc_valid_in(v), .acc_write_in(w), .acc_addr_in(a), .acc_wdata_in(d),
    .rd_valid_out(rv), .rd_data_out(rd), .sfr_valid_out(sv), .sfr_write_out(sw),
    .sfr_bank_out(sb), .sfr_addr_out(sa), .sfr_wdata_out(sd), .sfr_rdata_in(srd),
    .bank_sel_out(bo), .pointer_a_out(pao), .pointer_b_out(pbo)
  );
  bdm_sfr_model sfr_m (
    .clk_in(clk), .valid_in(sv), .write_in(sw), .addr_in(sa), .wdata_in(sd),
    .rdata_out(srd)
  );

  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    cmp_count++;
    if (got !== ex)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Target kind: 0 none, 1 ram, 2 pointer a, 3 pointer b, 4 bank, 5 external.
  function automatic int resolve(input logic [7:0] ad, output logic [7:0] e,
                                 output logic eb);
    logic n;
    n = ad == bdm_pkg::ADDR_IND_A || ad == bdm_pkg::ADDR_IND_B;
    e = ad == bdm_pkg::ADDR_IND_A ? pa : ad == bdm_pkg::ADDR_IND_B ? pb : ad;
    eb = ad == bdm_pkg::ADDR_IND_B ? bk : 1'b0;
    if (n && (e == bdm_pkg::ADDR_IND_A || e == bdm_pkg::ADDR_IND_B))
      return 0;
    if (e >= bdm_pkg::GP_BASE)
      return eb ? 0 : 1;
    if (e == bdm_pkg::ADDR_BANK1_ONLY && !eb)
      return 0;
    if (e == bdm_pkg::ADDR_PTR_A)
      return 2;
    if (e == bdm_pkg::ADDR_PTR_B)
      return 3;
    if (e == bdm_pkg::ADDR_BANK)
      return 4;
    return 5;
  endfunction

  task automatic acc(input logic vv, ww, input logic [7:0] aa, dd, input logic s, p);
    logic [7:0] e, x;
    logic       eb;
    int         k;
    v <= vv;
    w <= ww;
    a <= aa;
    d <= dd;
    sr <= s;
    wr <= p;
    k = vv ? resolve(aa, e, eb) : 0;
    x = k == 1 ? ram[e[6:0]] : k == 2 ? pa : k == 3 ? pb : k == 4 ? {7'h00, bk} :
        k == 5 ? sfr[e] : 8'h00;
    #1;
    chk("sfr_valid", {7'h00, k == 5}, {7'h00, sv});
    chk("sfr_write", {7'h00, k == 5 && ww}, {7'h00, sw});
    if (k == 5)
    begin
      chk("sfr_wdata", dd, sd);
      chk("sfr_addr", e, sa);
      chk("sfr_bank", {7'h00, eb}, {7'h00, sb});
    end
    @(posedge clk);
    if (vv && ww)
      case (k)
        1: ram[e[6:0]] = dd;
        2: pa = dd;
        3: pb = dd;
        4: bk = dd[0];
        5: sfr[e] = dd;
        default: ;
      endcase
    if (s)
      bk = 1'b0;
    @(negedge clk);
    chk("rd_valid", {7'h00, vv && !ww}, {7'h00, rv});
    if (vv && !ww)
      chk("rd_data", x, rd);
    chk("bank", {7'h00, bk}, {7'h00, bo});
    chk("pointer_a", pa, pao);
    chk("pointer_b", pb, pbo);
  endtask

  ////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    #(50 * 4000);
    n_mismatch++;
    test_done();
  end

  initial
  begin
    logic [7:0] ad;
    {rstn, sr, wr, v, w, a, d} = '0;
    {pa, pb, bk} = '0;
    for (int i = 0; i < 256; i++)
      sfr[i] = 8'(i) ^ 8'h5a;
    void'($urandom(77906));
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    chk("bank_por", 8'h00, {7'h00, bo});
    chk("ptr_por", 8'h00, pao | pbo);
    for (int i = 0; i < 128; i++)
      acc(1, 1, 8'h80 + 8'(i), 8'($urandom), 0, 0);
    acc(1, 1, 8'h04, 8'hff, 0, 0);
    acc(1, 1, 8'h03, 8'h40, 0, 0);
    acc(1, 1, 8'h02, 8'ha5, 0, 0);
    acc(1, 0, 8'h02, 8'h00, 0, 0);
    acc(1, 0, 8'h04, 8'h00, 0, 0);
    acc(1, 0, 8'h40, 8'h00, 0, 0);
    acc(1, 1, 8'h01, 8'h90, 0, 0);
    acc(1, 0, 8'h00, 8'h00, 0, 0);
    acc(1, 0, 8'h85, 8'h00, 0, 0);
    acc(0, 0, 8'h00, 8'h00, 0, 1);
    // A second power-on reset while bank 1 and both pointers are set.
    rstn = 1'b0;
    #1;
    chk("bank_rst", 8'h00, {7'h00, bo});
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    {pa, pb, bk} = '0;
    chk("ptr_rst", 8'h00, pao | pbo);
    acc(1, 1, 8'h03, 8'h02, 0, 0);
    acc(1, 1, 8'h02, 8'h77, 0, 0);
    acc(1, 0, 8'h02, 8'h00, 0, 0);
    acc(1, 1, 8'h01, 8'h02, 0, 0);
    acc(1, 0, 8'h00, 8'h00, 0, 0);
    acc(1, 1, 8'h80, 8'h3c, 0, 0);
    acc(1, 0, 8'h80, 8'h00, 0, 0);
    acc(1, 1, 8'h04, 8'h01, 1, 0);
    repeat (2000)
    begin
      ad = $urandom % 4 == 0 ? 8'($urandom % 5) : 8'($urandom);
      acc(($urandom % 8) != 0, 1'($urandom), ad, 8'($urandom),
          ($urandom % 32) == 0, ($urandom % 32) == 0);
    end
    test_done();
  end
endmodule
